/* word_divide_unit.sv */
// word divide unit: iterative signed and unsigned 32-bit divide into result pair
// ============================================================================
`timescale 1ns/1ns
module word_divide_unit (
    input  wire logic                          clock,
    input  wire logic                          resetn,
    input  wire word_divide_pkg::divide_req_t  request,
    input  wire logic                          readHighResult,
    input  wire logic                          readLowResult,
    output word_divide_pkg::result_pair_t      results,
    output logic                               busy,
    output logic                               readStall,
    output logic                               done,
    output logic                               overflowException
);
    import word_divide_pkg::*;

    // ========================================================================
    // operand decode
    // ========================================================================
    function automatic logic [31:0] magnitude(input logic [31:0] v, input logic neg);
        magnitude = neg ? (32'h00000000 - v) : v;
    endfunction

    wire logic [31:0] dividendWord = request.dividendSource[31:0];
    wire logic [31:0] divisorWord  = request.divisorSource[31:0];
    wire logic        dividendNeg  = request.isSigned & dividendWord[31];
    wire logic        divisorNeg   = request.isSigned & divisorWord[31];
    // unsigned: sign bits forced off, i.e. zero-extended magnitudes
    wire logic [31:0] dividendMag  = magnitude(dividendWord, dividendNeg);
    wire logic [31:0] divisorMagIn = magnitude(divisorWord, divisorNeg);

    // ========================================================================
    // state
    // ========================================================================
    divide_state_t state;
    divide_state_t next_state;
    logic [31:0]   remainder;
    logic [31:0]   quotient;
    logic [31:0]   divisorMag;
    logic [5:0]    stepsLeft;
    logic          quotNeg;
    logic          remNeg;
    logic          mode64;

    wire logic [31:0] stepRem;
    wire logic [31:0] stepQuot;

    divide_step stepUnit (
        .partialRem (remainder),
        .quotientIn (quotient),
        .divisorMag (divisorMag),
        .nextRem    (stepRem),
        .nextQuot   (stepQuot)
    );

    wire logic start    = (state == ST_IDLE) & request.valid;
    wire logic lastStep = (state == ST_DIVIDE) & (stepsLeft == 6'h01);

    always_comb begin
        next_state = state;
        unique case (state)
            ST_IDLE:   if (request.valid) next_state = ST_DIVIDE;
            ST_DIVIDE: if (lastStep) next_state = ST_FIXUP;
            ST_FIXUP:  next_state = ST_IDLE;
            default:   next_state = ST_IDLE;
        endcase
    end

    // ========================================================================
    // result fixup and sign extension
    // ========================================================================
    // zero divisor: the steps still run and leave some value, no flag raised
    wire logic [31:0] finalQuot  = magnitude(quotient, quotNeg);
    wire logic [31:0] finalRem   = magnitude(remainder, remNeg);
    wire logic [63:0] extQuot    = mode64 ? {{32{finalQuot[31]}}, finalQuot}
                                          : {32'h00000000, finalQuot};
    wire logic [63:0] extRem     = mode64 ? {{32{finalRem[31]}}, finalRem}
                                          : {32'h00000000, finalRem};
    wire logic        next_busy  = (next_state != ST_IDLE);
    wire logic        readReq    = readHighResult | readLowResult;

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state <= ST_IDLE;
            busy  <= 1'b0;
        end else begin
            state <= next_state;
            busy  <= next_busy;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            remainder  <= 32'h00000000;
            quotient   <= 32'h00000000;
            divisorMag <= 32'h00000000;
            stepsLeft  <= STEP_ZERO;
            quotNeg    <= 1'b0;
            remNeg     <= 1'b0;
            mode64     <= 1'b0;
        end else if (start) begin
            remainder  <= 32'h00000000;
            quotient   <= dividendMag;
            divisorMag <= divisorMagIn;
            stepsLeft  <= STEP_COUNT;
            quotNeg    <= dividendNeg ^ divisorNeg;
            remNeg     <= dividendNeg;
            mode64     <= request.mode64;
        end else if (state == ST_DIVIDE) begin
            remainder  <= stepRem;
            quotient   <= stepQuot;
            stepsLeft  <= stepsLeft - 6'h01;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            results <= {RESULT_INIT, RESULT_INIT};
            done    <= 1'b0;
        end else begin
            done <= (state == ST_FIXUP);
            if (state == ST_FIXUP) begin
                results.lowResult  <= extQuot;
                results.highResult <= extRem;
            end
        end
    end

    // stall a read while a divide is running or about to start
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            readStall <= 1'b0;
        end else begin
            readStall <= readReq & next_busy;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            overflowException <= 1'b0;
        end else begin
            overflowException <= 1'b0;
        end
    end

    // ========================================================================
    // assertions
    // ========================================================================
    AST_NO_OVERFLOW: assert property (@(posedge clock) disable iff (!resetn)
        !overflowException) else $error("divide raised overflow");

    AST_UNSIGNED_NO_OVF: assert property (@(posedge clock) disable iff (!resetn)
        start && !request.isSigned |-> ##[1:40] done && !overflowException)
        else $error("unsigned divide flagged overflow");

    AST_SIGNED_RESULT: assert property (@(posedge clock) disable iff (!resetn)
        start && request.isSigned && divisorWord != 32'h00000000
        && !(dividendWord == 32'h80000000 && divisorWord == 32'hFFFFFFFF)
        |-> ##34 (results.lowResult[31:0]
            == $past(32'($signed(dividendWord) / $signed(divisorWord)), 34)))
        else $error("signed quotient wrong");

    AST_UNSIGNED_RESULT: assert property (@(posedge clock) disable iff (!resetn)
        start && !request.isSigned && divisorWord != 32'h00000000
        |-> ##34 (results.lowResult[31:0] == $past(dividendWord / divisorWord, 34)))
        else $error("unsigned quotient wrong");

    AST_REMAINDER_HIGH: assert property (@(posedge clock) disable iff (!resetn)
        start && !request.isSigned && divisorWord != 32'h00000000
        |-> ##34 (results.highResult[31:0] == $past(dividendWord % divisorWord, 34)))
        else $error("remainder not in high result");

    AST_SIGN_EXTEND: assert property (@(posedge clock) disable iff (!resetn)
        $rose(done) && mode64 |->
        results.highResult[63:32] == {32{results.highResult[31]}}
        && results.lowResult[63:32] == {32{results.lowResult[31]}})
        else $error("results not sign-extended");

    AST_ZERO_DIVISOR_ENDS: assert property (@(posedge clock) disable iff (!resetn)
        start && divisorWord == 32'h00000000 |-> ##34 done)
        else $error("zero divisor did not finish");

    AST_READ_STALL: assert property (@(posedge clock) disable iff (!resetn)
        readReq && (state != ST_IDLE) && (next_state != ST_IDLE) |=> readStall)
        else $error("read not stalled during divide");

    AST_STALL_ONLY_BUSY: assert property (@(posedge clock) disable iff (!resetn)
        readStall |-> busy) else $error("stall without divide");

    AST_SIGNED_REMAINDER: assert property (@(posedge clock) disable iff (!resetn)
        start && request.isSigned && divisorWord != 32'h00000000
        && !(dividendWord == 32'h80000000 && divisorWord == 32'hFFFFFFFF)
        |-> ##34 (results.highResult[31:0]
            == $past(32'($signed(dividendWord) % $signed(divisorWord)), 34)))
        else $error("signed remainder wrong");

    AST_DONE_PULSE: assert property (@(posedge clock) disable iff (!resetn)
        done |=> !done) else $error("done longer than one cycle");

    AST_IDLE_AT_DONE: assert property (@(posedge clock) disable iff (!resetn)
        done |-> !busy && !readStall) else $error("busy or stall after results written");

    AST_UPPER_ZERO: assert property (@(posedge clock) disable iff (!resetn)
        $rose(done) && !mode64 |->
        results.highResult[63:32] == 32'h00000000
        && results.lowResult[63:32] == 32'h00000000)
        else $error("upper result half not zero");

    COV_SIGNED: cover property (@(posedge clock) disable iff (!resetn)
        start && request.isSigned && dividendNeg);
    COV_UNSIGNED: cover property (@(posedge clock) disable iff (!resetn)
        start && !request.isSigned);
    COV_MODE64: cover property (@(posedge clock) disable iff (!resetn)
        done && mode64);
    COV_STALL: cover property (@(posedge clock) disable iff (!resetn) readStall);
    COV_ZERO_DIVISOR: cover property (@(posedge clock) disable iff (!resetn)
        start && divisorWord == 32'h00000000);

endmodule // word_divide_unit

/* word_divide_pkg.sv */
// types and constants shared by the word divide unit
package word_divide_pkg;

    localparam int unsigned WORD_BITS   = 32;
    localparam int unsigned DWORD_BITS  = 64;
    localparam int unsigned STEP_BITS   = 6;
    // one quotient bit per cycle
    localparam logic [5:0]  STEP_COUNT  = 6'h20;
    localparam logic [5:0]  STEP_ZERO   = 6'h00;
    localparam logic [63:0] RESULT_INIT = 64'h0000000000000000;

    // divide request from the integer pipeline
    typedef struct packed {
        logic        valid;
        logic        isSigned;
        logic        mode64;
        logic [63:0] dividendSource;
        logic [63:0] divisorSource;
    } divide_req_t;

    // result register pair as seen by the pipeline
    typedef struct packed {
        logic [63:0] highResult;
        logic [63:0] lowResult;
    } result_pair_t;

    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_DIVIDE = 2'b01,
        ST_FIXUP  = 2'b10
    } divide_state_t;

endpackage

/* divide_step.sv */
// one restoring-division step on 32-bit magnitudes
`timescale 1ns/1ns
module divide_step (
    input  wire logic [31:0] partialRem,
    input  wire logic [31:0] quotientIn,
    input  wire logic [31:0] divisorMag,
    output logic      [31:0] nextRem,
    output logic      [31:0] nextQuot
);
    import word_divide_pkg::*;

    wire logic [32:0] shiftedRem = {partialRem, quotientIn[31]};
    wire logic [32:0] trialDiff  = shiftedRem - {1'b0, divisorMag};
    wire logic        fits       = ~trialDiff[32];

    assign nextRem  = fits ? trialDiff[31:0] : shiftedRem[31:0];
    assign nextQuot = {quotientIn[30:0], fits};

endmodule // divide_step

/* divide_issuer.sv */
// integer pipeline model that issues divides and result reads
`timescale 1ns/1ns
module divide_issuer (
    input  wire logic                   clock,
    input  wire logic                   busy,
    input  wire logic                   done,
    output word_divide_pkg::divide_req_t request,
    output logic                        readHighResult,
    output logic                        readLowResult
);
    import word_divide_pkg::*;

    initial begin
        request = '0;
        readHighResult = 1'b0;
        readLowResult = 1'b0;
    end

    // ==========================================================
    // one divide, optional refused request while busy
    task automatic send(input logic s, input logic m, input logic [31:0] a,
                        input logic [31:0] b, input logic [31:0] pat,
                        input logic poke, output logic late);
        late = 1'b1;
        @(posedge clock);
        readHighResult <= 1'b0;
        readLowResult <= 1'b0;
        repeat (2) @(posedge clock);
        request <= '{1'b1, s, m, {{32{a[31]}}, a}, {{32{b[31]}}, b}};
        @(posedge clock);
        request.valid <= 1'b0;
        for (int n = 0; n < 40; n++) begin
            @(posedge clock);
            if (done === 1'b1) begin
                late = 1'b0;
                break;
            end
            if (n < 30) begin
                readHighResult <= pat[n % 32];
                readLowResult <= pat[(n + 7) % 32];
            end
            if (poke && n == 5 && busy) request.valid <= 1'b1;
            if (poke && n == 6) request.valid <= 1'b0;
        end
        readHighResult <= 1'b0;
        readLowResult <= 1'b0;
    endtask
endmodule // divide_issuer

/* test_word_divide_unit.sv */
// self-checking bench for the word divide unit
`timescale 1ns/1ns
`define CHK(a, b, msg) begin samplesChecked++; if ((a) !== (b)) begin miscompares++; \
    $display("mismatch %0t %s", $time, msg); end end
module test_word_divide_unit;
    import word_divide_pkg::*;
    logic         clock;
    logic         resetn;
    divide_req_t  request;
    logic         readHighResult;
    logic         readLowResult;
    result_pair_t results;
    logic         busy;
    logic         readStall;
    logic         done;
    logic         overflowException;
    logic [128:0] noteQ[$];
    logic [128:0] note;
    logic         readLast;
    logic         busyLast;
    logic         doneLast;
    logic [5:0]   runLeft;
    logic         late;
    logic [31:0]  state;
    logic [31:0]  a;
    logic [31:0]  b;
    int           miscompares = 0;
    int           samplesChecked = 0;
    logic [31:0]  opA[6] = '{32'h00000007, 32'hFFFFFFF9, 32'h00000007, 32'h80000000,
                             32'hFFFFFFFF, 32'h00000005};
    logic [31:0]  opB[6] = '{32'h00000002, 32'h00000002, 32'hFFFFFFFE, 32'hFFFFFFFF,
                             32'h00000001, 32'h00000000};

    word_divide_unit dut (.clock(clock), .resetn(resetn), .request(request),
        .readHighResult(readHighResult), .readLowResult(readLowResult), .results(results),
        .busy(busy), .readStall(readStall), .done(done), .overflowException(overflowException));
    divide_issuer issuer (.clock(clock), .busy(busy), .done(done), .request(request),
        .readHighResult(readHighResult), .readLowResult(readLowResult));

    function automatic logic [31:0] rnd();
        state = state ^ (state << 13);
        state = state ^ (state >> 17);
        state = state ^ (state << 5);
        return state;
    endfunction

    function automatic logic [128:0] expectedPair(logic s, logic m, logic [31:0] x,
                                                  logic [31:0] y);
        logic [31:0] mx, my, q, r;
        mx = (s && x[31]) ? -x : x;
        my = (s && y[31]) ? -y : y;
        if (my == 32'h00000000) return '0;
        q = (s && (x[31] ^ y[31])) ? -(mx / my) : mx / my;
        r = (s && x[31]) ? -(mx % my) : mx % my;
        return {1'b1, m ? {32{r[31]}} : 32'h00000000, r, m ? {32{q[31]}} : 32'h00000000, q};
    endfunction

    task automatic finalReport();
        if (miscompares == 0 && samplesChecked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    task automatic run(logic s, logic m, logic [31:0] x, logic [31:0] y, logic poke);
        noteQ.push_back(expectedPair(s, m, x, y));
        issuer.send(s, m, x, y, rnd(), poke, late);
        `CHK(late, 1'b0, "no completion")
    endtask

    // ==========================================================
    // result watcher
    // own busy model: take on an idle edge, 32 steps, fixup, then idle
    wire logic taking = request.valid && runLeft == STEP_ZERO;
    wire logic inProg = taking || runLeft > 6'h01;
    always @(posedge clock) begin
        if (!resetn) begin
            readLast <= 1'b0;
            busyLast <= 1'b0;
            doneLast <= 1'b0;
            runLeft  <= STEP_ZERO;
        end else begin
            `CHK(readStall, readLast, "read stall")
            `CHK(busy, busyLast, "busy span")
            `CHK(done, doneLast, "done pulse")
            readLast <= (readHighResult | readLowResult) & inProg;
            busyLast <= inProg;
            doneLast <= runLeft == 6'h01;
            runLeft  <= taking ? STEP_COUNT + 6'h01
                               : ((runLeft != STEP_ZERO) ? runLeft - 6'h01 : STEP_ZERO);
            if (done === 1'b1) begin
                `CHK(overflowException, 1'b0, "overflow flag")
                if (noteQ.size() == 0) begin
                    `CHK(1'b1, 1'b0, "unexpected completion")
                end else begin
                    note = noteQ.pop_front();
                    if (note[128]) `CHK(results, note[127:0], "result pair")
                end
            end
        end
    end

    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    initial begin
        repeat (5000) @(posedge clock);
        miscompares++;
        finalReport();
    end

    initial begin
        resetn = 1'b0;
        state = 32'h00007E09;
        repeat (2) @(posedge clock);
        resetn <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            for (int k = 0; k < 4; k++) begin
                run(k[0], k[1], opA[i], opB[i], i == 2);
            end
        end
        repeat (16) begin
            a = rnd();
            b = rnd();
            run(a[0], a[1], a, b >> a[4:0], 1'b0);
        end
        repeat (3) @(posedge clock);
        finalReport();
    end
endmodule // test_word_divide_unit
